// file: hw/acc_adc_ctrl.sv
// control, status and successive-approximation sequencer of the 8-bit adc
// assumes an axi4-lite master on aclk and an analog comparator whose
// output is asynchronous to aclk
//
// Behaviour
// - a conversion starts only when software writes one to bit 5.
// - a start during a running conversion abandons it and begins afresh.
// - bit 5 of the control register always reads as zero.
// - writing the start bit clears the done flag at once.
// - a finished conversion sets done in bit 6 and requests an enabled irq.
// - writes never clear done; only a new start does.
// - bit 7 enables the end-of-conversion interrupt request.
// - bit 4 powers the converter on when one.
// - the result is valid only while done reads one.
// - in wait mode the done request wakes the core; stop disables the adc.
// - bit 2 drives the main-oscillator disable to the clock system.
// - the result sits read-only at index d0h and ignores writes.
// - after reset the control register reads 40h.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps

module acc_adc_ctrl
  import acc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              comp_above,
  input  wire logic              wait_mode,
  input  wire logic              stop_mode,
  output logic [7:0]             sar_code,
  output logic                   conv_busy,
  output logic                   converter_power_on,
  output logic                   main_osc_disable,
  output logic                   conv_irq_req,
  output logic                   wakeup_req,
  output logic                   irq
);

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == RESULT_IDX) reg_sel = SEL_RESULT;
    else if (idx == CTRL_IDX) reg_sel = SEL_CTRL;
    else if (idx == IRQ_STS_IDX) reg_sel = SEL_STS;
    else if (idx == IRQ_MSK_IDX) reg_sel = SEL_MSK;
    else reg_sel = SEL_NONE;
  endfunction

  logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic              wr_fire, ctrl_wr, start_wr, sts_wr, msk_wr;
  logic [2:0]        wr_sel, rd_sel;
  logic              ie_q, pwr_q, osc_q, done_q;
  logic [7:0]        result_q, trial_q, ctrl_view, code_now;
  logic [EVT_W-1:0]  sts_q, msk_q;
  acc_state_e        state_q;
  logic [2:0]        bit_idx_q;
  logic [STEP_W-1:0] step_cnt_q;
  logic              s1_q, s2_q, s3_q, comp_f_q;
  logic              abort, step_end, conv_finish;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data taken in either order

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready  = !w_hold_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_sel  = reg_sel(aw_addr_q);
  // registers live in byte lane 0 only, other lanes are dropped
  assign ctrl_wr  = wr_fire && w_lane0_q && (wr_sel == SEL_CTRL);
  assign sts_wr   = wr_fire && w_lane0_q && (wr_sel == SEL_STS);
  assign msk_wr   = wr_fire && w_lane0_q && (wr_sel == SEL_MSK);
  assign start_wr = ctrl_wr && w_data_q[START_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold_q  <= 1'b1;
      w_data_q  <= wdata[7:0];
      w_lane0_q <= wstrb[0];
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      // result writes are accepted and ignored
      bresp_q  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read side

  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign rd_sel  = reg_sel(araddr);
  // start bit never stored, reserved bits read zero
  assign ctrl_view = {ie_q, done_q, 1'b0, pwr_q, 1'b0, osc_q, 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rd_sel)
        SEL_RESULT: rdata_q <= {24'h000000, result_q};
        SEL_CTRL:   rdata_q <= {24'h000000, ctrl_view};
        SEL_STS:    rdata_q <= {{(DATA_W-EVT_W){1'b0}}, sts_q};
        SEL_MSK:    rdata_q <= {{(DATA_W-EVT_W){1'b0}}, msk_q};
        default:    rdata_q <= '0;
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_q  <= CTRL_RESET[IE_BIT];
      pwr_q <= CTRL_RESET[PWR_BIT];
      osc_q <= CTRL_RESET[OSC_BIT];
    end else if (ctrl_wr) begin
      ie_q  <= w_data_q[IE_BIT];
      pwr_q <= w_data_q[PWR_BIT];
      osc_q <= w_data_q[OSC_BIT];
    end
  end

  // a start in the finishing cycle abandons that result, so clear wins here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= CTRL_RESET[DONE_BIT];
    end else if (start_wr) begin
      done_q <= 1'b0;
    end else if (conv_finish) begin
      done_q <= 1'b1;
    end
  end

  assign converter_power_on = pwr_q;
  assign main_osc_disable   = osc_q;
  assign conv_irq_req       = done_q && ie_q;
  assign wakeup_req         = conv_irq_req && wait_mode && !stop_mode;

  ////////////////////////////////////////////////////////////////////////
  // comparator synchroniser, a change counts once stages two and three agree

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q     <= 1'b0;
      s2_q     <= 1'b0;
      s3_q     <= 1'b0;
      comp_f_q <= 1'b0;
    end else begin
      s1_q <= comp_above;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        comp_f_q <= s3_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive-approximation sequencer

  // comparator path latency is four cycles, so a step must be longer
  assign abort       = !pwr_q || stop_mode;
  assign step_end    = (step_cnt_q == STEP_W'(STEP_CYCLES - 1));
  assign conv_finish = (state_q == ACC_RUN) && !abort && !start_wr
                       && step_end && (bit_idx_q == 3'h0);
  assign code_now    = comp_f_q ? trial_q
                                : (trial_q & ~(8'h01 << bit_idx_q));
  assign sar_code    = trial_q;
  assign conv_busy   = (state_q == ACC_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ACC_IDLE;
      bit_idx_q  <= MSB_IDX;
      step_cnt_q <= '0;
      trial_q    <= 8'h00;
    end else if (start_wr) begin
      state_q    <= ACC_RUN;
      bit_idx_q  <= MSB_IDX;
      step_cnt_q <= '0;
      trial_q    <= 8'h80;
    end else begin
      unique case (state_q)
        ACC_IDLE: begin
          step_cnt_q <= '0;
        end
        ACC_RUN: begin
          if (abort) begin
            state_q <= ACC_IDLE;
          end else if (!step_end) begin
            step_cnt_q <= step_cnt_q + 1'b1;
          end else begin
            step_cnt_q <= '0;
            if (bit_idx_q == 3'h0) begin
              state_q <= ACC_IDLE;
              trial_q <= code_now;
            end else begin
              bit_idx_q <= bit_idx_q - 1'b1;
              trial_q   <= code_now | (8'h01 << (bit_idx_q - 1'b1));
            end
          end
        end
      endcase
    end
  end

  // reset only keeps checks free of unknowns, meaningless until the first conversion finishes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= '0;
    end else if (conv_finish) begin
      result_q <= code_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask, status set wins over a write-one clear

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      msk_q <= '0;
    end else begin
      sts_q[EVT_DONE] <= conv_finish
                         || (sts_q[EVT_DONE]
                             && !(sts_wr && w_data_q[EVT_DONE]));
      if (msk_wr) begin
        msk_q <= w_data_q[EVT_W-1:0];
      end
    end
  end

  assign irq = |(sts_q & msk_q);

  ////////////////////////////////////////////////////////////////////////
  // checks

  localparam int CONV_LEN = CONV_BITS * STEP_CYCLES;
  logic [LEN_W-1:0] run_len_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || start_wr || state_q == ACC_IDLE) begin
      run_len_q <= '0;
    end else begin
      run_len_q <= run_len_q + 1'b1;
    end
  end

  sequence s_restart;
    state_q == ACC_RUN && start_wr;
  endsequence
  sequence s_fresh;
    state_q == ACC_RUN && bit_idx_q == MSB_IDX && step_cnt_q == '0
      && trial_q == 8'h80;
  endsequence

  a_no_self_start: assert property (@(posedge aclk)
    disable iff (!aresetn)
    state_q == ACC_IDLE && !start_wr |=> state_q == ACC_IDLE)
    else $error("conversion began without a start write");
  a_restart_fresh: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_restart |=> s_fresh)
    else $error("start during conversion did not restart it");
  a_start_reads_zero: assert property (@(posedge aclk)
    disable iff (!aresetn)
    arvalid && arready && rd_sel == SEL_CTRL |=> !rdata_q[START_BIT])
    else $error("start bit read back as one");
  a_start_clears_done: assert property (@(posedge aclk)
    disable iff (!aresetn) start_wr |=> !done_q && !conv_irq_req)
    else $error("done flag survived a start");
  a_done_on_finish: assert property (@(posedge aclk)
    disable iff (!aresetn)
    conv_finish |=> done_q && (conv_irq_req == ie_q))
    else $error("finish did not raise done");
  a_done_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    done_q && !start_wr |=> done_q)
    else $error("done cleared without a start");
  a_ctrl_bits_land: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ctrl_wr |=> converter_power_on == $past(w_data_q[PWR_BIT])
      && main_osc_disable == $past(w_data_q[OSC_BIT])
      && ie_q == $past(w_data_q[IE_BIT]))
    else $error("control write not applied");
  a_stop_no_wake: assert property (@(posedge aclk)
    disable iff (!aresetn)
    stop_mode |-> !wakeup_req ##1 (state_q == ACC_IDLE || $past(start_wr)))
    else $error("converter active or waking in stop");
  a_result_stable: assert property (@(posedge aclk)
    disable iff (!aresetn) !conv_finish |=> $stable(result_q))
    else $error("result changed outside a finish");
  a_reset_value: assert property (@(posedge aclk)
    disable iff (!aresetn) !$past(aresetn) |-> ctrl_view == CTRL_RESET)
    else $error("control register not 40h after reset");
  a_conv_length: assert property (@(posedge aclk)
    disable iff (!aresetn)
    conv_finish |-> run_len_q == LEN_W'(CONV_LEN - 1))
    else $error("conversion length wrong");

endmodule

// file: hw/acc_pkg.sv
// package for the adc conversion control block
// assumes one 100 MHz core clock and an axi4-lite master with 32-bit data
package acc_pkg;

  // axi4-lite
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // register indexes, byte address is four times the index
  localparam logic [9:0]  RESULT_IDX  = 10'h0d0;
  localparam logic [9:0]  CTRL_IDX    = 10'h0d1;
  localparam logic [9:0]  IRQ_STS_IDX = 10'h0d8;
  localparam logic [9:0]  IRQ_MSK_IDX = 10'h0d9;

  // decoded register selects
  localparam logic [2:0]  SEL_NONE    = 3'h0;
  localparam logic [2:0]  SEL_RESULT  = 3'h1;
  localparam logic [2:0]  SEL_CTRL    = 3'h2;
  localparam logic [2:0]  SEL_STS     = 3'h3;
  localparam logic [2:0]  SEL_MSK     = 3'h4;

  // control register layout
  localparam int          IE_BIT      = 7;
  localparam int          DONE_BIT    = 6;
  localparam int          START_BIT   = 5;
  localparam int          PWR_BIT     = 4;
  localparam int          OSC_BIT     = 2;
  localparam logic [7:0]  CTRL_RESET  = 8'h40;

  // interrupt status layout
  localparam int          EVT_W       = 1;
  localparam int          EVT_DONE    = 0;

  // conversion timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STEP_TIME_NS  = 1000;
  localparam int          STEP_CYCLES   =
    (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONV_BITS     = 8;
  localparam int          STEP_W        = 8;
  localparam int          LEN_W         = 10;
  localparam logic [2:0]  MSB_IDX       = 3'h7;

  typedef enum logic {
    ACC_IDLE = 1'b0,
    ACC_RUN  = 1'b1
  } acc_state_e;

endpackage

// file: dv/acc_adc_model.sv
// analog side: comparator facing the trial code of the converter
// assumes vin is held steady by the bench during each conversion
`timescale 1ns/100ps

module acc_adc_model (
  input  wire logic       aclk,
  input  wire logic       power_on,
  input  wire logic [7:0] sar_code,
  input  wire logic [7:0] vin,
  output logic            comp_above
);
  logic junk_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // unpowered comparator gives no stable answer, so it toggles
  always @(posedge aclk) begin
    junk_q <= ~junk_q;
  end

  assign comp_above = power_on ? (vin >= sar_code) : junk_q;
endmodule

// file: dv/tb_adc_conversion_control.sv
// bench for the adc conversion control block, axi4-lite register access
// assumes acc_pkg and the comparator model are compiled first
`timescale 1ns/100ps

module tb_adc_conversion_control
  import acc_pkg::*;
;
  logic              aclk = 0, aresetn = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = 4'hf;
  logic [2:0]        awprot = 3'h0, arprot = 3'h0;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              comp_above, wait_mode = 0, stop_mode = 0;
  logic [7:0]        sar_code, vin = 8'h00;
  logic              conv_busy, converter_power_on, main_osc_disable;
  logic              conv_irq_req, wakeup_req, irq;
  int                miscompares = 0, n_checks = 0, seed = 64058, n;

  always #5 aclk = ~aclk;

  acc_adc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .comp_above(comp_above),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .sar_code(sar_code),
    .conv_busy(conv_busy), .converter_power_on(converter_power_on),
    .main_osc_disable(main_osc_disable), .conv_irq_req(conv_irq_req),
    .wakeup_req(wakeup_req), .irq(irq));

  acc_adc_model model (.aclk(aclk), .power_on(converter_power_on),
    .sar_code(sar_code), .vin(vin), .comp_above(comp_above));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] sar_expect(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (v >= (c | (8'h01 << b))) c = c | (8'h01 << b);
    end
    return c;
  endfunction

  // edge first so a strobe is never raised in the step it was dropped
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic got;
    got = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    // no limit here, the watchdog ends a hung handshake
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        got = 1;
        bready <= 0;
        chk(bresp, er);
      end
    end
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    logic got;
    got = 0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1;
    rready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        got = 1;
        rready <= 0;
        chk(rresp, er);
        chk(rdata, exp);
      end
    end
  endtask

  task automatic wait_idle(output int cnt);
    cnt = 0;
    @(posedge aclk);
    while (conv_busy === 1'b1 && cnt < 2000) begin
      @(posedge aclk);
      cnt++;
    end
    if (cnt >= 2000) chk(1'b0, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(CTRL_IDX, 8'h40);
    rd(IRQ_STS_IDX, 8'h00);
    rd(IRQ_MSK_IDX, 8'h00);
    rd(10'h0d2, 8'h00, RESP_SLVERR);
    wr(10'h0d2, 8'hff, RESP_SLVERR);
    wr(CTRL_IDX, 8'h14);
    chk(main_osc_disable, 1'b1);
    chk(converter_power_on, 1'b1);
    rd(CTRL_IDX, 8'h54);
    wr(CTRL_IDX, 8'h10);
    chk(main_osc_disable, 1'b0);
    wr(IRQ_MSK_IDX, 8'h01);
    // corner codes first, then random levels
    for (int i = 0; i < 5; i++) begin
      vin <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      wait_mode <= i[0];
      wr(CTRL_IDX, 8'hb0);
      rd(CTRL_IDX, 8'h90);
      chk(conv_irq_req, 1'b0);
      chk(conv_busy, 1'b1);
      wait_idle(n);
      rd(RESULT_IDX, sar_expect(vin));
      chk(sar_code, sar_expect(vin));
      rd(CTRL_IDX, 8'hd0);
      chk(conv_irq_req, 1'b1);
      chk(wakeup_req, i[0]);
      chk(irq, 1'b1);
      wr(IRQ_STS_IDX, 8'h01);
      chk(irq, 1'b0);
    end
    wait_mode <= 0;
    wr(CTRL_IDX, 8'h90);
    rd(CTRL_IDX, 8'hd0);
    wr(RESULT_IDX, ~vin);
    rd(RESULT_IDX, sar_expect(vin));
    wr(CTRL_IDX, 8'h10);
    chk(conv_irq_req, 1'b0);
    rd(CTRL_IDX, 8'h50);
    // restart mid-conversion with a new level, status masked
    wr(IRQ_MSK_IDX, 8'h00);
    vin <= 8'h5a;
    wr(CTRL_IDX, 8'h30);
    repeat (400) @(posedge aclk);
    vin <= 8'ha5;
    wr(CTRL_IDX, 8'h30);
    wait_idle(n);
    chk(n > 700, 1'b1);
    rd(RESULT_IDX, sar_expect(8'ha5));
    chk(irq, 1'b0);
    rd(IRQ_STS_IDX, 8'h01);
    // stop mode abandons and never wakes
    wait_mode <= 1;
    wr(CTRL_IDX, 8'hb0);
    repeat (50) @(posedge aclk);
    stop_mode <= 1;
    wait_idle(n);
    chk(n < 20, 1'b1);
    rd(CTRL_IDX, 8'h90);
    chk(wakeup_req, 1'b0);
    stop_mode <= 0;
    wait_mode <= 0;
    // power off abandons a running conversion
    wr(CTRL_IDX, 8'hb0);
    repeat (50) @(posedge aclk);
    wr(CTRL_IDX, 8'h80);
    wait_idle(n);
    chk(n < 20, 1'b1);
    chk(converter_power_on, 1'b0);
    rd(CTRL_IDX, 8'h80);
    // a write with byte lane 0 off must leave the register alone
    wstrb <= 4'he;
    wr(CTRL_IDX, 8'h10);
    wstrb <= 4'hf;
    rd(CTRL_IDX, 8'h80);
    chk(converter_power_on, 1'b0);
    tally_and_finish;
  end
endmodule
